// File: common/err_count_pkg.sv
package err_count_pkg;

   // register offsets
   localparam logic [7:0] VIOLATION_COUNT_HI_ADDR      = 8'h00;
   localparam logic [7:0] VIOLATION_COUNT_LO_ADDR      = 8'h01;
   localparam logic [7:0] FRAMING_CRC_UPPER_ADDR       = 8'h02;
   localparam logic [7:0] CRC_WORD_ERROR_COUNT_LO_ADDR = 8'h03;
   localparam logic [7:0] FRAMING_EBIT_MID_ADDR        = 8'h04;
   localparam logic [7:0] FAR_END_ERROR_COUNT_LO_ADDR  = 8'h05;
   localparam logic [7:0] STATUS_TWO_FLAGS_ADDR        = 8'h07;
   localparam logic [7:0] STATUS2_INTERRUPT_MASK_ADDR  = 8'h17;
   localparam logic [7:0] COMMON_CONTROL_ONE_ADDR      = 8'h18;
   localparam logic [7:0] COMMON_CONTROL_TWO_ADDR      = 8'h19;
   localparam logic [7:0] STATUS_TWO_CLEAR_ADDR        = 8'h1a;

   // field positions
   localparam int CTL1_HDB3_BIT      = 2;  // receive hdb3 decoding on
   localparam int CTL1_CRC4_BIT      = 0;  // crc4 multiframe operation
   localparam int CTL2_INTERVAL_BIT  = 7;  // 1 selects the short interval
   localparam int CTL2_VIOL_TYPE_BIT = 6;  // 1 counts code violations
   localparam int STATUS_TIMER_BIT   = 4;  // interval timer event

   // reset values
   localparam logic [7:0] MASK_RESET   = 8'h00;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // widths and limits
   localparam int VIOL_W  = 16;
   localparam int CRC_W   = 10;
   localparam int EBIT_W  = 10;
   localparam int FAS_W   = 12;
   localparam int TIMER_W = 25;
   localparam logic [VIOL_W-1:0] VIOL_MAX = 16'hffff;

   // timing
   localparam int CLOCK_PERIOD_NS   = 50;
   localparam int LONG_INTERVAL_NS  = 1000000000;
   localparam int SHORT_INTERVAL_NS = 62500000;
   localparam int LONG_INTERVAL_CYCLES  = LONG_INTERVAL_NS / CLOCK_PERIOD_NS;
   localparam int SHORT_INTERVAL_CYCLES = SHORT_INTERVAL_NS / CLOCK_PERIOD_NS;

endpackage

// File: design/e1_error_counter_bank.sv
`timescale 1ns/1ns
// Operation
// - mask register gates each status-two event
// - counters update each second or 62.5 ms
// - violation count high byte 0x00, low 0x01
// - select 0 counts bipolar violations, skip hdb3
// - select 1 counts code violations
// - violation counter never gated by sync
// - violation counter saturates at 65535
// - crc4 count split across 0x02 and 0x03
// - crc and e-bit stop on fas/crc loss
// - e-bit zero in crc4 mode adds one
// - e-bit count split across 0x04 and 0x05
// - fas count split across 0x02 and 0x04
// - fas counter stops on frame sync loss
// - timer flag each second or 62.5 ms
module e1_error_counter_bank #(
   parameter int LONG_CYCLES  = err_count_pkg::LONG_INTERVAL_CYCLES,
   parameter int SHORT_CYCLES = err_count_pkg::SHORT_INTERVAL_CYCLES
) (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // received line symbols, one strobe per bit time
   input  wire logic       bit_strobe_i,
   input  wire logic       mark_pos_i,
   input  wire logic       mark_neg_i,
   // framer error events
   input  wire logic       crc_error_i,
   input  wire logic       ebit_strobe_i,
   input  wire logic       ebit_value_i,
   input  wire logic       fas_error_i,
   // synchronisation state
   input  wire logic       frame_sync_lost_i,
   input  wire logic       crc_mf_sync_lost_i,
   // other status-two events, bit 4 is ignored
   input  wire logic [7:0] event_i,
   // interrupt
   output logic            irq_o
);

   // register map seen by the host:
   //   0x00 violation count, bits 15..8
   //   0x01 violation count, bits 7..0
   //   0x02 align errors 11..6 above crc errors 9..8
   //   0x03 crc errors 7..0
   //   0x04 align errors 5..0 above far-end errors 9..8
   //   0x05 far-end errors 7..0
   //   0x07 status two, sticky, read only
   //   0x17 status two interrupt mask
   //   0x18 control one, 0x19 control two
   //   0x1a status two clear, write only
   // the count bytes show the last finished interval only;
   // the host has one interval to fetch them before they move

   // violation modes, picked by control two bit 6:
   //   0: count every bipolar violation; with hdb3 receive
   //      decoding on, a violation after two zeros belongs to
   //      a substitution code and is skipped
   //   1: count code violations, a violation whose polarity
   //      matches the previous violation
   // the violation count runs in every sync state and stops
   // at its top value rather than wrapping

   // interval timing: control two bit 7 picks one second or
   // 62.5 ms, counted in receive clock cycles; each tick sets
   // status bit 4, moves all four running counts into the
   // readable totals and restarts the running counts
   // the interrupt is the or of status bits under their mask

   // limits a user must know:
   //   - a count read as two bytes may straddle a boundary, so
   //     the high and low bytes can belong to two intervals;
   //     read soon after the timer interrupt to avoid this
   //   - selecting the short interval while the timer is past
   //     its end gives a tick on the next edge
   //   - events are one-cycle pulses; a longer pulse counts
   //     once for every cycle that it stays high
   //   - marks are only looked at in cycles with the bit strobe
   //   - an event in the cycle of a status clear stays set,
   //     so no event is lost
   //   - unmapped offsets and the clear register read zero
   //   - writes to read-only offsets are ignored

   // whole state of the block
   typedef struct packed {

      // interval timer
      logic [err_count_pkg::TIMER_W-1:0] timer;

      // counts of the open interval
      logic [err_count_pkg::VIOL_W-1:0]  viol_run;
      logic [err_count_pkg::CRC_W-1:0]   crc_run;
      logic [err_count_pkg::EBIT_W-1:0]  ebit_run;
      logic [err_count_pkg::FAS_W-1:0]   fas_run;

      // totals of the last finished interval
      logic [err_count_pkg::VIOL_W-1:0]  viol_hold;
      logic [err_count_pkg::CRC_W-1:0]   crc_hold;
      logic [err_count_pkg::EBIT_W-1:0]  ebit_hold;
      logic [err_count_pkg::FAS_W-1:0]   fas_hold;

      // line history for violation detection
      logic                              seen_mark;
      logic                              last_pol;
      logic [1:0]                        zeros;
      logic                              seen_bpv;
      logic                              last_bpv_pol;

      // host registers
      logic [7:0]                        mask;
      logic [7:0]                        ctl1;
      logic [7:0]                        ctl2;
      logic [7:0]                        status;

      // read data stage
      logic [7:0]                        rdata;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   // count step that starts afresh at a boundary
   // a tick drops the old running value, so an event in the
   // tick cycle becomes the first count of the new interval;
   // the limit stops the step, giving saturation instead of a
   // wrap; the narrow counters pass their full range as limit,
   // which they cannot reach within one interval
   function automatic logic [15:0] step16(
      input logic [15:0] cur,
      input logic        tick,
      input logic        inc,
      input logic [15:0] lim
   );
      logic [15:0] base;
      // restart from zero on a tick
      base = tick ? 16'h0000 : cur;
      // step unless already at the limit
      if (inc && (base != lim)) begin
         step16 = base + 16'h0001;
      end else begin
         step16 = base;
      end
   endfunction

   // read multiplexer
   // two bytes are shared: the align error count fills the
   // upper six bits at 0x02 and 0x04, the crc and far-end
   // counts their two low bits; nothing is latched between
   // bytes, the held totals only move at a boundary
   // the read uses the registered state, so a write in the
   // cycle before a read is already visible
   function automatic logic [7:0] read_mux(
      input state_t    s,
      input logic [7:0] a
   );
      // plain address compare, one branch per byte
      if (a == err_count_pkg::VIOLATION_COUNT_HI_ADDR) begin
         read_mux = s.viol_hold[15:8];
      end else if (a == err_count_pkg::VIOLATION_COUNT_LO_ADDR) begin
         read_mux = s.viol_hold[7:0];
      end else if (a == err_count_pkg::FRAMING_CRC_UPPER_ADDR) begin
         read_mux = {s.fas_hold[11:6], s.crc_hold[9:8]};
      end else if (a == err_count_pkg::CRC_WORD_ERROR_COUNT_LO_ADDR) begin
         read_mux = s.crc_hold[7:0];
      end else if (a == err_count_pkg::FRAMING_EBIT_MID_ADDR) begin
         read_mux = {s.fas_hold[5:0], s.ebit_hold[9:8]};
      end else if (a == err_count_pkg::FAR_END_ERROR_COUNT_LO_ADDR) begin
         read_mux = s.ebit_hold[7:0];
      end else if (a == err_count_pkg::STATUS_TWO_FLAGS_ADDR) begin
         read_mux = s.status;
      end else if (a == err_count_pkg::STATUS2_INTERRUPT_MASK_ADDR) begin
         read_mux = s.mask;
      end else if (a == err_count_pkg::COMMON_CONTROL_ONE_ADDR) begin
         read_mux = s.ctl1;
      end else if (a == err_count_pkg::COMMON_CONTROL_TWO_ADDR) begin
         read_mux = s.ctl2;
      end else begin
         read_mux = 8'h00; // unmapped and write-only read zero
      end
   endfunction

   // interval lengths at the timer width
   // the timer counts from zero, so the last value is one less
   localparam logic [err_count_pkg::TIMER_W-1:0] LONG_LAST =
      err_count_pkg::TIMER_W'(LONG_CYCLES - 1);
   localparam logic [err_count_pkg::TIMER_W-1:0] SHORT_LAST =
      err_count_pkg::TIMER_W'(SHORT_CYCLES - 1);

   // next-state logic
   always_comb begin
      // working values, all given a default first
      logic [err_count_pkg::TIMER_W-1:0] last;
      logic                              tick;
      logic                              mark;
      logic                              pol;
      logic                              bpv;
      logic                              hdb3_sub;
      logic                              viol_inc;
      logic                              crc_ok;
      logic                              crc_inc;
      logic                              ebit_inc;
      logic                              fas_inc;
      logic [7:0]                        set;
      logic [7:0]                        clr;
      logic [15:0]                       tmp;
      // defaults keep every path assigned
      last     = SHORT_LAST;
      tick     = 1'b0;
      mark     = 1'b0;
      pol      = 1'b0;
      bpv      = 1'b0;
      hdb3_sub = 1'b0;
      viol_inc = 1'b0;
      crc_ok   = 1'b0;
      crc_inc  = 1'b0;
      ebit_inc = 1'b0;
      fas_inc  = 1'b0;
      set      = 8'h00;
      clr      = 8'h00;
      tmp      = 16'h0000;
      // hold every field unless a branch below moves it
      state_nxt = state_r;

      // interval timer on the receive clock
      // the compare is >= so that a switch to the short interval
      // while the timer is already past its end ticks at once
      // instead of running round the whole counter
      if (state_r.ctl2[err_count_pkg::CTL2_INTERVAL_BIT]) begin
         last = SHORT_LAST;
      end else begin
         last = LONG_LAST;
      end
      if (state_r.timer >= last) begin
         tick = 1'b1;
         state_nxt.timer = '0;
      end else begin
         state_nxt.timer = state_r.timer + 1'b1;
      end

      // line symbol tracking for violations
      // a mark is one rail high; both or neither is a zero
      // the zero run saturates at two, enough for the
      // substitution test below
      // a violation is a mark of the same polarity as the
      // previous mark, whatever lies between them
      mark = mark_pos_i ^ mark_neg_i;
      pol  = mark_pos_i;
      if (bit_strobe_i) begin
         if (mark) begin
            bpv = state_r.seen_mark && (pol == state_r.last_pol);
            // a violation after two zeros is an hdb3 substitution
            hdb3_sub = state_r.ctl1[err_count_pkg::CTL1_HDB3_BIT] &&
                       (state_r.zeros == 2'h2);
            state_nxt.seen_mark = 1'b1;
            state_nxt.last_pol  = pol;
            state_nxt.zeros     = 2'h0;
         end else if (state_r.zeros != 2'h2) begin
            state_nxt.zeros = state_r.zeros + 2'h1;
         end
      end
      // select between plain violations and code violations;
      // the polarity of every violation is kept for the second
      if (state_r.ctl2[err_count_pkg::CTL2_VIOL_TYPE_BIT]) begin
         // code violation: bpv with the same polarity as the last bpv
         viol_inc = bpv && state_r.seen_bpv &&
                    (pol == state_r.last_bpv_pol);
      end else begin
         viol_inc = bpv && !hdb3_sub;
      end
      if (bpv) begin
         state_nxt.seen_bpv     = 1'b1;
         state_nxt.last_bpv_pol = pol;
      end

      // sync gating of the framing counters
      // the crc and far-end counts need frame and crc multiframe
      // sync; the align word count only needs frame sync; a loss
      // of signalling multiframe sync gates none of them
      // far-end bits only count in crc4 multiframe operation
      crc_ok   = !frame_sync_lost_i && !crc_mf_sync_lost_i;
      crc_inc  = crc_error_i && crc_ok;
      ebit_inc = ebit_strobe_i && !ebit_value_i && crc_ok &&
                 state_r.ctl1[err_count_pkg::CTL1_CRC4_BIT];
      fas_inc  = fas_error_i && !frame_sync_lost_i;

      // running counts, violation count ungated and saturating
      // crc and far-end counts cannot pass 1000 per second and
      // align errors 4000, so their limits are never reached
      state_nxt.viol_run = step16(state_r.viol_run, tick, viol_inc,
                                  err_count_pkg::VIOL_MAX);
      tmp = step16({6'h00, state_r.crc_run}, tick, crc_inc, 16'h03ff);
      state_nxt.crc_run = tmp[9:0];
      tmp = step16({6'h00, state_r.ebit_run}, tick, ebit_inc, 16'h03ff);
      state_nxt.ebit_run = tmp[9:0];
      tmp = step16({4'h0, state_r.fas_run}, tick, fas_inc, 16'h0fff);
      state_nxt.fas_run = tmp[11:0];

      // boundary copies the finished interval
      // the held totals are taken from the registered running
      // counts, so the event of the tick cycle goes to the new
      // interval and is never lost or counted twice
      if (tick) begin
         state_nxt.viol_hold = state_r.viol_run;
         state_nxt.crc_hold  = state_r.crc_run;
         state_nxt.ebit_hold = state_r.ebit_run;
         state_nxt.fas_hold  = state_r.fas_run;
      end

      // control writes
      // writes to the count bytes and to status are ignored;
      // the clear register only exists as a write strobe
      if (wr_i) begin
         if (addr_i == err_count_pkg::STATUS2_INTERRUPT_MASK_ADDR) begin
            state_nxt.mask = wdata_i;
         end else if (addr_i == err_count_pkg::COMMON_CONTROL_ONE_ADDR) begin
            state_nxt.ctl1 = wdata_i;
         end else if (addr_i == err_count_pkg::COMMON_CONTROL_TWO_ADDR) begin
            state_nxt.ctl2 = wdata_i;
         end else if (addr_i == err_count_pkg::STATUS_TWO_CLEAR_ADDR) begin
            clr = wdata_i;
         end
      end

      // sticky status, a new event beats a clear
      // bit 4 of the event input is replaced by the timer tick
      // so that only the internal timer can raise it
      set = event_i;
      set[err_count_pkg::STATUS_TIMER_BIT] = tick;
      state_nxt.status = (state_r.status & ~clr) | set;

      // read data stands the cycle after the strobe only
      // a zero outside the read slot keeps the bus quiet
      if (rd_i) begin
         state_nxt.rdata = read_mux(state_r, addr_i);
      end else begin
         state_nxt.rdata = 8'h00;
      end
   end

   // state register
   // every field clears on reset: all counts, the mask, both
   // control bytes and the sticky status start at zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r              <= '0;
         state_r.mask         <= err_count_pkg::MASK_RESET;
         state_r.ctl1         <= err_count_pkg::CTL_RESET;
         state_r.ctl2         <= err_count_pkg::CTL_RESET;
         state_r.status       <= err_count_pkg::STATUS_RESET;
      end else begin
         // the next state is taken whole on every edge
         state_r <= state_nxt;
      end
   end

   // outputs
   // read data comes straight from a flip-flop; the interrupt
   // is a level that follows status and mask after each edge
   // and drops only after a clear or a mask write
   assign rdata_o = state_r.rdata;
   assign irq_o   = |(state_r.status & state_r.mask);

endmodule // e1_error_counter_bank

// File: testbench/host_bus.sv
`timescale 1ns/1ns
// host side of the register port, one strobe per access
module host_bus (
   // clock
   input  wire logic       clock_i,
   // register port
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   // idle bus at time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // one-cycle write, data inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clock_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask
   // one-cycle read, address left on the bus after the strobe drops
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clock_i);
      rd_o   <= 1'b0;
   endtask
endmodule // host_bus

// File: testbench/e1_error_counter_bank_chk.sv
`timescale 1ns/1ns
// register port and interrupt checks
module e1_error_counter_bank_chk (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic [7:0] rdata_o,
   // events and interrupt
   input  wire logic [7:0] event_i,
   input  wire logic       irq_o
);
   localparam logic [7:0] MSK = err_count_pkg::STATUS2_INTERRUPT_MASK_ADDR;
   localparam logic [7:0] CT2 = err_count_pkg::COMMON_CONTROL_TWO_ADDR;
   logic [7:0] mask_r;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // shadow of the mask register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_r <= 8'h00;
      end else if (wr_i && addr_i == MSK) begin
         mask_r <= wdata_i;
      end
   end
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside read slot");
   a_mask_readback: assert property (wr_i && addr_i == MSK ##1 !wr_i
      ##1 rd_i && addr_i == MSK |=> rdata_o == $past(wdata_i, 3))
      else $error("mask read back differs");
   a_ctl_readback: assert property (wr_i && addr_i == CT2 ##1 !wr_i
      ##1 rd_i && addr_i == CT2 |=> rdata_o[7:6] == $past(wdata_i[7:6], 3))
      else $error("control two read back differs");
   a_unmapped_zero: assert property (rd_i && addr_i >= 8'h1a
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   a_irq_enabled: assert property (!wr_i && |(event_i & mask_r & 8'hef)
      |=> irq_o) else $error("enabled event gave no interrupt");
   a_irq_masked: assert property (mask_r == 8'h00 |-> !irq_o)
      else $error("interrupt with all bits masked");
   a_clear_drop: assert property (wr_i && addr_i == 8'h1a
      && wdata_i == 8'hff && (event_i & 8'hef) == 8'h00 && !mask_r[4]
      |=> !irq_o) else $error("interrupt stays after full clear");
   a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i))
      else $error("interrupt dropped without a write");
   c_irq: cover property ($rose(irq_o));
   c_mask_rb: cover property (wr_i && addr_i == MSK ##2 rd_i);
   c_clear: cover property (wr_i && addr_i == 8'h1a);
endmodule // e1_error_counter_bank_chk

bind e1_error_counter_bank e1_error_counter_bank_chk chk_u (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .event_i(event_i), .irq_o(irq_o));

// File: testbench/tb_top.sv
`timescale 1ns/1ns
// bench: host model drives the port, a watcher checks reads
module tb_top;
   localparam int LONG  = 60;
   localparam int SHORT = 12;
   logic       clock_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       bit_strobe_i = 1'b0;
   logic       mark_pos_i = 1'b0;
   logic       mark_neg_i = 1'b0;
   logic       fs_lost = 1'b0;
   logic       mf_lost = 1'b0;
   logic       rd_d = 1'b0;
   logic [3:0] ev_r = 4'h0; // crc, ebit strobe, ebit value, fas
   logic [7:0] event_i = 8'h00;
   logic [7:0] addr_i, wdata_i, rdata_o, exp_q[$];
   logic       wr_i, rd_i, irq_o;
   int         n_fail = 0, checks_done = 0, cyc = 0, t0, t1, nc;
   e1_error_counter_bank #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) dut_u (
      .clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .bit_strobe_i, .mark_pos_i, .mark_neg_i, .crc_error_i(ev_r[3]),
      .ebit_strobe_i(ev_r[2]), .ebit_value_i(ev_r[1]),
      .fas_error_i(ev_r[0]), .frame_sync_lost_i(fs_lost),
      .crc_mf_sync_lost_i(mf_lost), .event_i, .irq_o);
   host_bus host_u (.clock_i, .addr_o(addr_i), .wdata_o(wdata_i),
      .wr_o(wr_i), .rd_o(rd_i));
   always #25 clock_i = ~clock_i;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watcher: read answer against oldest note, plus cycle limit
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      rd_d <= rd_i;
      if (rd_d) chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
      if (cyc == 4000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(a);
   endtask
   task automatic rdall(input logic [15:0] v, input logic [9:0] c,
                        input logic [9:0] e, input logic [11:0] f);
      rdx(8'h00, v[15:8]);
      rdx(8'h01, v[7:0]);
      rdx(8'h02, {f[11:6], c[9:8]});
      rdx(8'h03, c[7:0]);
      rdx(8'h04, {f[5:0], e[9:8]});
      rdx(8'h05, e[7:0]);
   endtask
   // one cycle of framer error pulses
   task automatic ev(input logic [3:0] v);
      @(posedge clock_i);
      ev_r <= v;
      @(posedge clock_i);
      ev_r <= 4'h0;
   endtask
   // status-two event pulse, then let the interrupt settle
   task automatic pulse(input logic [7:0] v);
      @(posedge clock_i);
      event_i <= v;
      @(posedge clock_i);
      event_i <= 8'h00;
      #1;
   endtask
   // nine line symbols, two bits each: positive, negative mark
   task automatic seq(input logic [17:0] s);
      for (int i = 8; i >= 0; i--) begin
         @(posedge clock_i);
         bit_strobe_i <= 1'b1;
         {mark_pos_i, mark_neg_i} <= s[2*i +: 2];
         @(posedge clock_i);
         bit_strobe_i <= 1'b0;
      end
   endtask
   // wait for the timer interrupt, note the cycle, clear status
   task automatic tick(output int t);
      do begin
         @(posedge clock_i);
         #1;
      end while (irq_o !== 1'b1);
      t = cyc;
      host_u.wr(8'h1a, 8'hff);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h4b52));
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rdx(8'h17, 8'h00);
      rdall(16'h0000, 10'h000, 10'h000, 12'h000);
      nc = $urandom;
      host_u.wr(8'h17, nc[7:0]);
      rdx(8'h17, nc[7:0]);
      for (int b = 0; b < 8; b++) begin
         if (b == 4) continue;
         host_u.wr(8'h17, 8'h01 << b);
         host_u.wr(8'h1a, 8'hff);
         pulse(8'hef & ~(8'h01 << b));
         chk({15'h0000, irq_o}, 16'h0000);
         pulse(8'h01 << b);
         chk({15'h0000, irq_o}, 16'h0001);
      end
      seq(18'b10);
      host_u.wr(8'h18, 8'h05);
      host_u.wr(8'h19, 8'h00);
      host_u.wr(8'h17, 8'h10);
      host_u.wr(8'h1a, 8'hff);
      tick(t0);
      nc = $urandom % 4 + 1;
      repeat (nc) ev(4'b1000);
      repeat (2) ev(4'b0100);
      ev(4'b0110);
      repeat (5) ev(4'b0001);
      mf_lost <= 1'b1;
      ev(4'b1101);
      mf_lost <= 1'b0;
      fs_lost <= 1'b1;
      ev(4'b1101);
      seq(18'b000101101000001010);
      fs_lost <= 1'b0;
      tick(t1);
      chk(16'(t1 - t0), 16'(LONG));
      rdall(16'd3, 10'(nc), 10'd2, 12'd6);
      host_u.wr(8'h19, 8'h40);
      rdx(8'h19, 8'h40);
      seq(18'b000000010101101010);
      repeat (2) ev(4'b1000);
      mf_lost <= 1'b1;
      ev(4'b1000);
      mf_lost <= 1'b0;
      ev(4'b0001);
      tick(t1);
      rdall(16'd2, 10'd2, 10'd0, 12'd1);
      host_u.wr(8'h01, 8'hff);
      rdx(8'h01, 8'h02);
      host_u.wr(8'h19, 8'hc0);
      tick(t0);
      tick(t1);
      chk(16'(t1 - t0), 16'(SHORT));
      rdx(8'h1a, 8'h00);
      rdx(8'h40, 8'h00);
      repeat (2) @(posedge clock_i);
      final_report();
   end
endmodule // tb_top
